/* logic/dcs_colour_top.sv */
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
`include "dcs_params.svh"
// Function
// RULE_01: brightness is set in eight levels, 1 to 8, and drives display duty.
// RULE_02: basic colour is green or red; the other one is the active colour.
// RULE_03: each relay with its enable on turns active colour when it becomes active.
// RULE_04: with alarm enable on, an alarm situation turns the active colour.
// RULE_05: extra threshold enable adds a setpoint comparison source; off means no effect.
// RULE_06: rising sense fires once result exceeds setpoint plus half band.
// RULE_07: falling sense fires once result drops below setpoint minus half band.
// RULE_08: setpoint is signed, -999 to 9999, the centre of the band.
// RULE_09: half band is 0 to 999; change only with result outside band.
// RULE_10: software keeps setpoint plus and minus half band inside measure range.
// RULE_11: with key acknowledge on, any key clears events and restores basic colour.
// RULE_12: out of range lamp lights while input is outside permissible range.
// RULE_13: range borders come from lower and upper extensions; too low or too high.
// RULE_14: events stay latched until acknowledged; active colour while any enabled pends.
module dcs_colour_top #(
    parameter int PWM_DIV = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic relay_one_active,
    input wire logic relay_two_active,
    input wire logic alarm_active,
    input wire logic key_pressed,
    input wire logic [15:0] result,
    input wire logic [11:0] input_level,
    output logic display_red,
    output logic display_lit,
    output logic [3:0] bright_level,
    output logic out_of_range_lamp,
    output logic irq
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    dcs_pkg::dcs_bus_e bus_reg;
    dcs_pkg::dcs_ctrl_s ctrl_reg;
    logic [15:0] sp_reg;
    logic [9:0] hy_reg;
    logic [9:0] lo_ext_reg;
    logic [7:0] hi_ext_reg;
    logic [`DCS_IRQ_W-1:0] status_reg;
    logic [`DCS_IRQ_W-1:0] mask_reg;
    logic [`DCS_EV_W-1:0] ev_reg;
    logic [`DCS_EV_W-1:0] ev_fire;
    logic [`DCS_EV_W-1:0] ev_en;
    logic [`DCS_IRQ_W-1:0] irq_set;
    logic [`DCS_IRQ_W-1:0] irq_clr;
    logic [31:0] rd_next;
    logic [31:0] wmask;
    logic [31:0] wval;
    logic wr_fire;
    logic relay_one_prev;
    logic relay_two_prev;
    logic alarm_prev;
    logic key_prev;
    logic lamp_prev;
    logic beyond_reg;
    logic beyond_set;
    logic beyond_clr;
    logic signed [16:0] res_ext;
    logic signed [16:0] upper_band;
    logic signed [16:0] lower_band;
    logic above;
    logic below;
    logic ack_fire;
    logic pending;
    logic lamp_next;
    logic [15:0] div_cnt;
    logic pwm_tick;
    logic [2:0] pwm_step;
    dcs_range_if rng();

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] clamp_sp(input logic [15:0] v);
        logic [15:0] r;
        r = v;
        if ($signed(v) < $signed(`DCS_SP_MIN))
            r = `DCS_SP_MIN;
        else if ($signed(v) > $signed(`DCS_SP_MAX))
            r = `DCS_SP_MAX;
        return r;
    endfunction

    function automatic logic [9:0] clamp10(input logic [15:0] v, input logic [9:0] lim);
        logic [9:0] r;
        r = (v > 16'(lim)) ? lim : v[9:0];
        return r;
    endfunction

    // ----------------------------------------
    // avalon slave
    // ----------------------------------------
    // one wait cycle always: request seen in idle, answered the next cycle
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            bus_reg <= dcs_pkg::BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end
        else
        begin
            unique case (bus_reg)
                dcs_pkg::BUS_IDLE:
                begin
                    if (avs_read || avs_write)
                    begin
                        bus_reg <= dcs_pkg::BUS_ACK;
                        avs_waitrequest <= 1'b0;
                        avs_readdata <= avs_read ? rd_next : 32'h0000_0000;
                    end
                end
                dcs_pkg::BUS_ACK:
                begin
                    bus_reg <= dcs_pkg::BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    assign wr_fire = (bus_reg == dcs_pkg::BUS_ACK) && avs_write;
    assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wval = avs_writedata & wmask;

    always_comb
    begin
        rd_next = 32'h0000_0000;
        unique case (avs_address)
            `DCS_OFF_CTRL: rd_next = 32'(ctrl_reg);
            `DCS_OFF_COLOUR_SETPOINT: rd_next = {{16{sp_reg[15]}}, sp_reg};
            `DCS_OFF_COLOUR_BAND_HALF: rd_next = 32'(hy_reg);
            `DCS_OFF_RANGE: rd_next = {8'h00, hi_ext_reg, 6'h00, lo_ext_reg};
            `DCS_OFF_STATUS: rd_next = 32'(status_reg);
            `DCS_OFF_MASK: rd_next = 32'(mask_reg);
            `DCS_OFF_STATE: rd_next = {20'h0_0000, bright_level, ev_reg,
                beyond_reg, out_of_range_lamp, display_red, display_lit};
            default: rd_next = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
            ctrl_reg <= `DCS_CTRL_RESET;
        else if (wr_fire && avs_address == `DCS_OFF_CTRL)
            ctrl_reg <= (ctrl_reg & ~wmask[`DCS_CTRL_W-1:0]) | wval[`DCS_CTRL_W-1:0];
    end

    // RULE_08 setpoint limits
    always_ff @(posedge clk)
    begin
        if (reset)
            sp_reg <= 16'h0000;
        else if (wr_fire && avs_address == `DCS_OFF_COLOUR_SETPOINT)
            sp_reg <= clamp_sp((sp_reg & ~wmask[15:0]) | wval[15:0]);
    end

    // RULE_09 half band limit
    always_ff @(posedge clk)
    begin
        if (reset)
            hy_reg <= 10'h000;
        else if (wr_fire && avs_address == `DCS_OFF_COLOUR_BAND_HALF)
            hy_reg <= clamp10((16'(hy_reg) & ~wmask[15:0]) | wval[15:0], `DCS_HY_MAX);
    end

    // RULE_13 range extensions
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            lo_ext_reg <= 10'h000;
            hi_ext_reg <= 8'h00;
        end
        else if (wr_fire && avs_address == `DCS_OFF_RANGE)
        begin
            lo_ext_reg <= clamp10((16'(lo_ext_reg) & ~wmask[15:0]) | wval[15:0],
                `DCS_LO_MAX);
            hi_ext_reg <= 8'(clamp10(16'(wval[23:`DCS_RANGE_HI_LSB])
                | (16'(hi_ext_reg) & ~16'(wmask[23:`DCS_RANGE_HI_LSB])),
                10'(`DCS_HI_MAX)));
        end
    end

    // ----------------------------------------
    // source edges
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            relay_one_prev <= 1'b0;
            relay_two_prev <= 1'b0;
            alarm_prev <= 1'b0;
            key_prev <= 1'b0;
            lamp_prev <= 1'b0;
        end
        else
        begin
            relay_one_prev <= relay_one_active;
            relay_two_prev <= relay_two_active;
            alarm_prev <= alarm_active;
            key_prev <= key_pressed;
            lamp_prev <= lamp_next;
        end
    end

    // ----------------------------------------
    // extra threshold with band
    // ----------------------------------------
    assign res_ext = {result[15], result};
    assign upper_band = {sp_reg[15], sp_reg} + {7'h00, hy_reg};
    assign lower_band = {sp_reg[15], sp_reg} - {7'h00, hy_reg};
    assign above = res_ext > upper_band;
    assign below = res_ext < lower_band;
    // RULE_06 rising sense
    // RULE_07 falling sense, below the band rather than above it
    assign beyond_set = !beyond_reg && (ctrl_reg.falling_sense ? below : above);
    assign beyond_clr = beyond_reg && (ctrl_reg.falling_sense ? above : below);

    // RULE_09 state moves only outside the band
    always_ff @(posedge clk)
    begin
        if (reset)
            beyond_reg <= 1'b0;
        else if (beyond_set)
            beyond_reg <= 1'b1;
        else if (beyond_clr)
            beyond_reg <= 1'b0;
    end

    // ----------------------------------------
    // colour events
    // ----------------------------------------
    assign ev_en = {ctrl_reg.extra_threshold_enable, ctrl_reg.alarm_colour_enable,
        ctrl_reg.relay_two_colour_enable, ctrl_reg.relay_one_colour_enable};
    // RULE_03 relay sources
    // RULE_04 alarm source
    // RULE_05 threshold source gate
    assign ev_fire = ev_en & {beyond_set, alarm_active && !alarm_prev,
        relay_two_active && !relay_two_prev, relay_one_active && !relay_one_prev};
    // RULE_11 key acknowledge
    assign ack_fire = ctrl_reg.key_acknowledge_enable && key_pressed && !key_prev;

    // RULE_14 latch until acknowledged; a new event beats the clear
    always_ff @(posedge clk)
    begin
        if (reset)
            ev_reg <= '0;
        else
            ev_reg <= (ev_reg & ~{`DCS_EV_W{ack_fire}}) | ev_fire;
    end

    assign pending = |(ev_reg & ev_en);

    // RULE_02 basic or active colour
    always_ff @(posedge clk)
    begin
        if (reset)
            display_red <= 1'b0;
        else
            display_red <= ctrl_reg.base_is_emerald ? pending : !pending;
    end

    // ----------------------------------------
    // range lamp
    // ----------------------------------------
    assign rng.level = input_level;
    assign rng.live_zero = ctrl_reg.live_zero;
    assign rng.lower_range_extension = lo_ext_reg;
    assign rng.upper_range_extension = hi_ext_reg;
    assign lamp_next = rng.too_low || rng.too_high;

    dcs_range_check u_range (
        .clk(clk),
        .reset(reset),
        .rng(rng.chk)
    );

    // RULE_12 lamp follows range flags
    always_ff @(posedge clk)
    begin
        if (reset)
            out_of_range_lamp <= 1'b0;
        else
            out_of_range_lamp <= lamp_next;
    end

    // ----------------------------------------
    // brightness
    // ----------------------------------------
    // duty steps run off a divider enable so the display sees a slow pwm
    always_ff @(posedge clk)
    begin
        if (reset)
            div_cnt <= 16'h0000;
        else if (pwm_tick)
            div_cnt <= 16'h0000;
        else
            div_cnt <= div_cnt + 16'h0001;
    end

    assign pwm_tick = div_cnt == 16'(PWM_DIV - 1);

    always_ff @(posedge clk)
    begin
        if (reset)
            pwm_step <= 3'h0;
        else if (pwm_tick)
            pwm_step <= (pwm_step == `DCS_BRIGHT_STEPS) ? 3'h0 : pwm_step + 3'h1;
    end

    // RULE_01 level 1..8 and duty
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            bright_level <= 4'h8;
            display_lit <= 1'b0;
        end
        else
        begin
            bright_level <= {1'b0, ctrl_reg.bright_code} + 4'h1;
            display_lit <= {1'b0, pwm_step} < bright_level;
        end
    end

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    assign irq_set = {lamp_next && !lamp_prev, ev_fire};
    assign irq_clr = (wr_fire && avs_address == `DCS_OFF_STATUS)
        ? wval[`DCS_IRQ_W-1:0] : '0;

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge clk)
    begin
        if (reset)
            status_reg <= '0;
        else
            status_reg <= (status_reg & ~irq_clr) | irq_set;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            mask_reg <= '0;
        else if (wr_fire && avs_address == `DCS_OFF_MASK)
            mask_reg <= (mask_reg & ~wmask[`DCS_IRQ_W-1:0]) | wval[`DCS_IRQ_W-1:0];
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            irq <= 1'b0;
        else
            irq <= |(status_reg & mask_reg);
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_relay_one_rise;
        relay_one_active && !relay_one_prev && ctrl_reg.relay_one_colour_enable;
    endsequence

    property p_bright;
        ##1 bright_level == {1'b0, $past(ctrl_reg.bright_code)} + 4'h1;
    endproperty
    a_bright: assert property (p_bright) // RULE_01
        else $error("brightness level not code plus one");

    property p_colour;
        ##1 display_red == ($past(ctrl_reg.base_is_emerald) ? $past(pending) : !$past(pending));
    endproperty
    a_colour: assert property (p_colour) // RULE_02
        else $error("display colour wrong for pending state");

    property p_relay;
        s_relay_one_rise |=> ev_reg[0] ##1 (display_red == ctrl_reg.base_is_emerald
            || !ctrl_reg.relay_one_colour_enable || $past(ev_reg[0] == 1'b0));
    endproperty
    a_relay: assert property (p_relay) // RULE_03
        else $error("relay one event not latched");

    property p_alarm;
        (!ctrl_reg.alarm_colour_enable && !ev_reg[2]) |=> !ev_reg[2];
    endproperty
    a_alarm: assert property (p_alarm) // RULE_04
        else $error("disabled alarm latched an event");

    property p_thr_off;
        (!ctrl_reg.extra_threshold_enable && !ev_reg[3]) |=> !ev_reg[3];
    endproperty
    a_thr_off: assert property (p_thr_off) // RULE_05
        else $error("disabled threshold latched an event");

    property p_rise;
        (ctrl_reg.extra_threshold_enable && !ctrl_reg.falling_sense && !beyond_reg && above)
            |=> beyond_reg && ev_reg[3];
    endproperty
    a_rise: assert property (p_rise) // RULE_06
        else $error("rising crossing missed");

    property p_fall;
        (ctrl_reg.extra_threshold_enable && ctrl_reg.falling_sense && !beyond_reg && below)
            |=> beyond_reg && ev_reg[3];
    endproperty
    a_fall: assert property (p_fall) // RULE_07
        else $error("falling crossing missed");

    property p_sp;
        $signed(sp_reg) >= $signed(`DCS_SP_MIN) && $signed(sp_reg) <= $signed(`DCS_SP_MAX);
    endproperty
    a_sp: assert property (p_sp) // RULE_08
        else $error("setpoint outside limits");

    property p_band;
        $changed(beyond_reg) |-> $past(above || below) && hy_reg <= `DCS_HY_MAX;
    endproperty
    a_band: assert property (p_band) // RULE_09
        else $error("band state changed inside band");

    property p_ack;
        (ack_fire && ev_fire == '0) |=> ev_reg == '0 ##1 (display_red != ctrl_reg.base_is_emerald
            || ev_reg != '0 || $changed(ctrl_reg));
    endproperty
    a_ack: assert property (p_ack) // RULE_11
        else $error("acknowledge left events pending");

    property p_lamp;
        lamp_next |=> out_of_range_lamp;
    endproperty
    a_lamp: assert property (p_lamp) // RULE_12
        else $error("lamp not lit out of range");

    property p_hold;
        !ack_fire |=> (ev_reg & $past(ev_reg)) == $past(ev_reg);
    endproperty
    a_hold: assert property (p_hold) // RULE_14
        else $error("latched event dropped without acknowledge");

    property p_bus;
        (bus_reg == dcs_pkg::BUS_IDLE && (avs_read || avs_write))
            |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_bus: assert property (p_bus)
        else $error("bus answer not one cycle");
endmodule
`default_nettype wire

/* logic/dcs_params.svh */
`ifndef DCS_PARAMS_SVH
`define DCS_PARAMS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DCS_OFF_CTRL 8'h00
`define DCS_OFF_COLOUR_SETPOINT 8'h04
`define DCS_OFF_COLOUR_BAND_HALF 8'h08
`define DCS_OFF_RANGE 8'h0C
`define DCS_OFF_STATUS 8'h10
`define DCS_OFF_MASK 8'h14
`define DCS_OFF_STATE 8'h18
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define DCS_CTRL_W 11
`define DCS_CTRL_RESET 11'h381
`define DCS_RANGE_HI_LSB 16
`define DCS_EV_W 4
`define DCS_IRQ_W 5
`define DCS_IRQ_LAMP 4
// ----------------------------------------
// limits
// ----------------------------------------
`define DCS_SP_MIN 16'hFC19
`define DCS_SP_MAX 16'h270F
`define DCS_HY_MAX 10'h3E7
`define DCS_LO_MAX 10'h3E7
`define DCS_HI_MAX 8'hC7
`define DCS_NOM_FULL 16'h03E8
`define DCS_LIVE_ZERO_DIV 16'h0005
`define DCS_BRIGHT_STEPS 3'h7
`endif

/* logic/dcs_pkg.sv */
`default_nettype none
package dcs_pkg;
    typedef enum logic {BUS_IDLE, BUS_ACK} dcs_bus_e;
    typedef struct packed {
        logic live_zero;
        logic [2:0] bright_code;
        logic key_acknowledge_enable;
        logic falling_sense;
        logic extra_threshold_enable;
        logic alarm_colour_enable;
        logic relay_two_colour_enable;
        logic relay_one_colour_enable;
        logic base_is_emerald;
    } dcs_ctrl_s;
endpackage
`default_nettype wire

/* logic/dcs_range_check.sv */
`timescale 1ns/1ns
`default_nettype none
`include "dcs_params.svh"
module dcs_range_check (
    input wire logic clk,
    input wire logic reset,
    dcs_range_if.chk rng
);
    // level is in 0.1 % of full scale; a live zero sits at one fifth of it
    logic [15:0] scaled;
    logic [15:0] lo_border5;
    logic [15:0] hi_border;
    assign scaled = 16'(rng.level) * `DCS_LIVE_ZERO_DIV;
    assign lo_border5 = `DCS_NOM_FULL - 16'(rng.lower_range_extension);
    assign hi_border = `DCS_NOM_FULL + 16'(rng.upper_range_extension);

    // RULE_13 border comparison
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rng.too_low <= 1'b0;
            rng.too_high <= 1'b0;
        end
        else
        begin
            rng.too_low <= rng.live_zero && (scaled < lo_border5);
            rng.too_high <= 16'(rng.level) > hi_border;
        end
    end

    property p_too_high;
        @(posedge clk) disable iff (reset)
        (16'(rng.level) > hi_border) |=> rng.too_high;
    endproperty
    a_too_high: assert property (p_too_high) // RULE_13
        else $error("too high not flagged above upper border");

    property p_zero_based;
        @(posedge clk) disable iff (reset)
        (!rng.live_zero) |=> !rng.too_low;
    endproperty
    a_zero_based: assert property (p_zero_based) // RULE_13
        else $error("too low flagged on zero based range");
endmodule
`default_nettype wire

/* logic/dcs_range_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface dcs_range_if;
    logic [11:0] level;
    logic live_zero;
    logic [9:0] lower_range_extension;
    logic [7:0] upper_range_extension;
    logic too_low;
    logic too_high;
    modport ctl(output level, live_zero, lower_range_extension, upper_range_extension,
        input too_low, too_high);
    modport chk(input level, live_zero, lower_range_extension, upper_range_extension,
        output too_low, too_high);
endinterface
`default_nettype wire

/* tb/display_colour_signalling_test.sv */
`timescale 1ns/1ns
`default_nettype none
`include "dcs_params.svh"
`define TB_CHK(got, exp, msg) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("mismatch at %0t ns: %s", $time, msg); \
        end \
    end
module display_colour_signalling_test;
    localparam int LIMIT = 5000;
    logic clk, reset, avs_read, avs_write, avs_waitrequest, irq;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, d;
    logic [3:0] avs_byteenable, bright_level;
    logic relay_one_active, relay_two_active, alarm_active, key_pressed;
    logic [15:0] result;
    logic [11:0] input_level;
    logic display_red, display_lit, out_of_range_lamp;
    int n_mismatch = 0;
    int n_checks = 0;
    int cycles = 0;
    int lit;

    dcs_colour_top #(.PWM_DIV(2)) dcs_colour_top_i (.clk(clk), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .relay_one_active(relay_one_active), .relay_two_active(relay_two_active),
        .alarm_active(alarm_active), .key_pressed(key_pressed), .result(result),
        .input_level(input_level), .display_red(display_red), .display_lit(display_lit),
        .bright_level(bright_level), .out_of_range_lamp(out_of_range_lamp), .irq(irq));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ----------------------------------------
    // bus cycles and helpers
    // ----------------------------------------
    // called at a rising edge; request held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
        input logic [3:0] be, output logic [31:0] rdata);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= wd;
        avs_byteenable <= be;
        avs_read <= !w;
        avs_write <= w;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
        begin
            n++;
            @(posedge clk);
        end
        `TB_CHK(n, 1, "bus answer not after one wait cycle");
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] x;
        bus(1'b1, a, wd, 4'hF, x);
    endtask

    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h00000000, 4'hF, d);
    endtask

    // event latch then colour take two edges past the input edge
    task automatic settle;
        repeat (4) @(posedge clk);
    endtask

    task automatic press_key;
        key_pressed <= 1'b1;
        settle;
        key_pressed <= 1'b0;
        settle;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        `TB_CHK(bright_level, 4'h8, "reset brightness");
        `TB_CHK(display_red, 1'b0, "reset colour");
        rd(`DCS_OFF_CTRL);
        `TB_CHK(d, 32'h00000381, "ctrl reset");
        rd(`DCS_OFF_MASK);
        `TB_CHK(d, 32'h00000000, "mask reset");
        wr(8'h40, 32'hFFFFFFFF);
        rd(8'h40);
        `TB_CHK(d, 32'h00000000, "unmapped read");
        bus(1'b1, `DCS_OFF_CTRL, 32'hFFFFFF00, 4'h1, d);
        rd(`DCS_OFF_CTRL);
        `TB_CHK(d, 32'h00000300, "lane write");
        $display("test reset done");
    endtask

    task automatic t_bright;
        for (int c = 0; c < 8; c++)
        begin
            wr(`DCS_OFF_CTRL, {22'h0, c[2:0], 7'h01});
            settle;
            `TB_CHK(bright_level, 4'(c + 1), "brightness level");
            lit = 0;
            repeat (64)
            begin
                @(posedge clk);
                lit += (display_lit === 1'b1) ? 1 : 0;
            end
            `TB_CHK(lit, (c + 1) * 8, "display duty");
        end
        $display("test brightness done");
    endtask

    task automatic t_relay;
        wr(`DCS_OFF_CTRL, 32'h00000383);
        relay_two_active <= 1'b1;
        settle;
        `TB_CHK(display_red, 1'b0, "disabled relay");
        relay_one_active <= 1'b1;
        settle;
        `TB_CHK(display_red, 1'b1, "relay colour");
        `TB_CHK(irq, 1'b0, "masked irq");
        relay_one_active <= 1'b0;
        press_key;
        `TB_CHK(display_red, 1'b1, "latched, ack off");
        wr(`DCS_OFF_CTRL, 32'h000003C3);
        press_key;
        `TB_CHK(display_red, 1'b0, "ack restores");
        rd(`DCS_OFF_STATUS);
        `TB_CHK(d[1:0], 2'b01, "status relays");
        wr(`DCS_OFF_MASK, 32'h00000001);
        settle;
        `TB_CHK(irq, 1'b1, "irq raised");
        wr(`DCS_OFF_STATUS, 32'h00000001);
        settle;
        `TB_CHK(irq, 1'b0, "irq cleared");
        relay_two_active <= 1'b0;
        $display("test relay done");
    endtask

    task automatic t_alarm;
        wr(`DCS_OFF_CTRL, 32'h000003CC);
        settle;
        `TB_CHK(display_red, 1'b1, "red base");
        alarm_active <= 1'b1;
        settle;
        `TB_CHK(display_red, 1'b0, "alarm colour");
        alarm_active <= 1'b0;
        press_key;
        `TB_CHK(display_red, 1'b1, "alarm ack");
        relay_two_active <= 1'b1;
        settle;
        `TB_CHK(display_red, 1'b0, "relay two colour");
        relay_two_active <= 1'b0;
        press_key;
        `TB_CHK(display_red, 1'b1, "relay two ack");
        $display("test alarm done");
    endtask

    task automatic t_thresh;
        // band kept inside the measuring range
        wr(`DCS_OFF_COLOUR_SETPOINT, 32'h00000064);
        wr(`DCS_OFF_COLOUR_BAND_HALF, 32'h0000000A);
        wr(`DCS_OFF_CTRL, 32'h000003D1);
        result <= 16'h006E;
        settle;
        `TB_CHK(display_red, 1'b0, "band edge");
        result <= 16'h006F;
        settle;
        `TB_CHK(display_red, 1'b1, "rising fire");
        result <= 16'h0050;
        press_key;
        `TB_CHK(display_red, 1'b0, "ack");
        result <= 16'h005F;
        wr(`DCS_OFF_CTRL, 32'h000003F1);
        result <= 16'h005A;
        settle;
        `TB_CHK(display_red, 1'b0, "falling edge");
        result <= 16'h0059;
        settle;
        `TB_CHK(display_red, 1'b1, "falling fire");
        wr(`DCS_OFF_CTRL, 32'h000003C1);
        press_key;
        result <= 16'h01F4;
        settle;
        result <= 16'h0000;
        settle;
        `TB_CHK(display_red, 1'b0, "source off");
        rd(`DCS_OFF_STATE);
        `TB_CHK(d[7:4], 4'h0, "no threshold event");
        wr(`DCS_OFF_COLOUR_SETPOINT, 32'h00002710);
        rd(`DCS_OFF_COLOUR_SETPOINT);
        `TB_CHK(d, 32'h0000270F, "setpoint top");
        wr(`DCS_OFF_COLOUR_SETPOINT, 32'hFFFFFC18);
        rd(`DCS_OFF_COLOUR_SETPOINT);
        `TB_CHK(d, 32'hFFFFFC19, "setpoint bottom");
        wr(`DCS_OFF_COLOUR_BAND_HALF, 32'h000003E8);
        rd(`DCS_OFF_COLOUR_BAND_HALF);
        `TB_CHK(d, 32'h000003E7, "half band top");
        $display("test threshold done");
    endtask

    task automatic t_lamp;
        wr(`DCS_OFF_RANGE, 32'h006400C8);
        input_level <= 12'h44C;
        settle;
        `TB_CHK(out_of_range_lamp, 1'b0, "upper border");
        input_level <= 12'h44D;
        settle;
        `TB_CHK(out_of_range_lamp, 1'b1, "too high");
        rd(`DCS_OFF_STATUS);
        `TB_CHK(d[4], 1'b1, "lamp status");
        input_level <= 12'h09F;
        settle;
        `TB_CHK(out_of_range_lamp, 1'b0, "no live zero");
        wr(`DCS_OFF_CTRL, 32'h00000781);
        input_level <= 12'h0A0;
        settle;
        `TB_CHK(out_of_range_lamp, 1'b0, "lower border");
        input_level <= 12'h09F;
        settle;
        `TB_CHK(out_of_range_lamp, 1'b1, "too low");
        $display("test lamp done");
    endtask

    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            n_mismatch++;
            $display("mismatch at %0t ns: run timed out", $time);
            final_report;
        end
    end

    initial
    begin
        reset = 1'b1;
        {avs_read, avs_write, relay_one_active, relay_two_active} = 4'h0;
        {alarm_active, key_pressed} = 2'h0;
        avs_address = 8'h00;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'hF;
        result = 16'h0000;
        input_level = 12'h1F4;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_reset;
        t_bright;
        t_relay;
        t_alarm;
        t_thresh;
        t_lamp;
        final_report;
    end
endmodule
`default_nettype wire
